// [src/bstd_regs.sv]
// buffer size capability word and per-queue submission tail doorbells.
// assumes the strobe master holds each strobe one cycle, never both,
// and that stride and queue depths are steady while doorbells are written.
`timescale 1ns/1ps
module bstd_regs (
  input  wire logic                                   clk,             // 40 MHz
  input  wire logic                                   reset_n,         // async, low
  input  wire bstd_pkg::bstd_bus_req_t                bus_req,         // strobe port
  output logic      [bstd_pkg::DATA_W-1:0]            rdata,           // read data
  input  wire logic [bstd_pkg::STRIDE_W-1:0]          doorbell_stride, // spacing code
  input  wire logic [bstd_pkg::NQ-1:0][bstd_pkg::DEPTH_W-1:0] queue_depth, // entries
  input  wire logic [bstd_pkg::NQ-1:0]                queue_live,      // queue exists
  input  wire logic [bstd_pkg::NQ-1:0]                fetch_taken,     // one fetched
  output logic      [bstd_pkg::NQ-1:0]                tail_rung,       // tail pulse
  output logic      [bstd_pkg::NQ-1:0][bstd_pkg::PTR_W-1:0]   tail_pointer_value,
  output logic      [bstd_pkg::NQ-1:0][bstd_pkg::DEPTH_W-1:0] added_count,
  output logic      [bstd_pkg::NQ-1:0][bstd_pkg::DEPTH_W-1:0] pending_count,
  output logic                                        stray_write,     // no such queue
  output logic      [bstd_pkg::UNIT_W-1:0]            usable_units,    // clipped size
  output logic      [bstd_pkg::UNIT_W-1:0]            buffer_start_offset, // location
  output bstd_pkg::bstd_place_t                       placement        // buffer uses
);
  import bstd_pkg::*;

  typedef struct packed {
    logic [NQ-1:0][PTR_W-1:0]   tail;
    logic [NQ-1:0][DEPTH_W-1:0] added;
    logic [NQ-1:0][DEPTH_W-1:0] pending;
    logic [NQ-1:0]              rung;
    logic                       stray;
    logic [DATA_W-1:0]          rdata;
    logic [UNIT_W-1:0]          usable;
    logic [UNIT_W-1:0]          start;
    bstd_place_t                place;
  } bstd_state_t;

  bstd_state_t state_reg;
  bstd_state_t state_next;

  // ---------------------------------------------------------------
  // capability word, built once from implementation constants
  // ---------------------------------------------------------------
  logic              gran_ok;
  logic              present;
  logic              sq_report;
  logic [DATA_W-1:0] size_word;
  logic [UNIT_W-1:0] window_room;
  logic [UNIT_W-1:0] usable_calc;
  bstd_place_t       place_calc;

  always_comb begin
    // a reserved granularity code would mislead software, so such a
    // build reports no buffer at all rather than a bogus code
    gran_ok   = (BUF_GRAN <= GRAN_64G);
    present   = BUF_PRESENT & gran_ok;
    // list support needs queues in the buffer too
    sq_report = BUF_SQ | BUF_LISTS;
    if (present) begin
      size_word = {BUF_CAPACITY,
                   BUF_GRAN,
                   {RSV_W{1'b0}},
                   BUF_WR,
                   BUF_RD,
                   BUF_LISTS,
                   BUF_CQ,
                   sq_report};
    end else begin
      size_word = ZERO_WORD;
    end
  end

  always_comb begin
    if (BUF_START >= WINDOW_UNITS) begin
      window_room = ZERO_UNIT;
    end else begin
      window_room = WINDOW_UNITS - BUF_START;
    end
    if (!present) begin
      usable_calc = ZERO_UNIT;
    end else if (BUF_CAPACITY > window_room) begin
      usable_calc = window_room;
    end else begin
      usable_calc = BUF_CAPACITY;
    end
  end

  // the controller's own data paths follow the reported bits exactly,
  // so host and controller never disagree on where things may live
  always_comb begin
    place_calc.wr_payload = size_word[WR_BIT];
    place_calc.rd_payload = size_word[RD_BIT];
    place_calc.lists      = size_word[LIST_BIT];
    place_calc.cq         = size_word[CQ_BIT];
    place_calc.sq         = size_word[SQ_BIT];
  end

  // ---------------------------------------------------------------
  // doorbell decode
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] db_offset;
  logic [DATA_W-1:0] db_mask;
  logic [DATA_W-1:0] db_index;
  logic [5:0]        db_shift;
  logic              db_region;
  logic              db_aligned;
  logic              db_tail_slot;
  logic              db_in_range;
  logic              db_hit;
  logic [QID_W-1:0]  db_qid;
  logic              size_hit;

  always_comb begin
    db_shift     = 6'(DB_WORD_SHIFT) + 6'(doorbell_stride);
    db_region    = (bus_req.addr >= OFS_DB_BASE);
    db_offset    = DATA_W'(bus_req.addr - OFS_DB_BASE);
    db_mask      = (32'h0000_0001 << db_shift) - 32'h0000_0001;
    db_aligned   = ((db_offset & db_mask) == ZERO_WORD);
    db_index     = db_offset >> db_shift;
    // even slots are tails; odd slots belong to completion heads
    db_tail_slot = ~db_index[0];
    db_in_range  = ((db_index >> 1) < DATA_W'(NQ));
    db_hit       = db_region & db_aligned & db_tail_slot & db_in_range;
    db_qid       = db_index[QID_W:1];
    size_hit     = (bus_req.addr == OFS_BUF_SIZE);
  end

  // ---------------------------------------------------------------
  // per-queue distance from the stored tail to the written one
  // ---------------------------------------------------------------
  logic [NQ-1:0][DEPTH_W-1:0] delta;

  genvar q;
  generate
    for (q = 0; q < NQ; q++) begin : g_delta
      bstd_tail_delta u_delta (
        .old_tail (state_reg.tail[q]),
        .new_tail (bus_req.wdata[PTR_W-1:0]),
        .depth    (queue_depth[q]),
        .added    (delta[q])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [NQ-1:0] ring_now;
  logic          live_hit;

  always_comb begin
    state_next = state_reg;
    ring_now   = '0;
    live_hit   = 1'b0;

    state_next.usable = usable_calc;
    if (present) begin
      state_next.start = BUF_START;
    end else begin
      state_next.start = ZERO_UNIT;
    end
    state_next.place = place_calc;

    // pulses last one cycle
    state_next.rung  = '0;
    state_next.stray = 1'b0;

    if (bus_req.wr && db_hit) begin
      live_hit = queue_live[db_qid];
      // a queue that was never created keeps its old tail; the event
      // is reported so firmware can see the host misbehaving
      if (live_hit) begin
        ring_now[db_qid] = 1'b1;
      end else begin
        state_next.stray = 1'b1;
      end
    end

    for (int i = 0; i < NQ; i++) begin
      if (ring_now[i]) begin
        // only the low half is kept; the upper half is reserved
        state_next.tail[i]  = bus_req.wdata[PTR_W-1:0];
        state_next.added[i] = delta[i];
        state_next.rung[i]  = 1'b1;
      end
      // a new ring and a fetch in the same cycle both count
      // a fetch with nothing pending and nothing added must not underflow
      if (ring_now[i] && fetch_taken[i] &&
          (state_reg.pending[i] != ZERO_CNT || delta[i] != ZERO_CNT)) begin
        state_next.pending[i] = state_reg.pending[i] + delta[i] -
                                DEPTH_W'(1);
      end else if (ring_now[i]) begin
        state_next.pending[i] = state_reg.pending[i] + delta[i];
      end else if (fetch_taken[i] && state_reg.pending[i] != ZERO_CNT) begin
        state_next.pending[i] = state_reg.pending[i] - DEPTH_W'(1);
      end
    end

    // read data stands only in the cycle after the strobe
    state_next.rdata = ZERO_WORD;
    if (bus_req.rd) begin
      if (size_hit) begin
        state_next.rdata = size_word;
      end else if (db_hit) begin
        // tail readback is this design's chosen value
        state_next.rdata = {{(DATA_W-PTR_W){1'b0}}, state_reg.tail[db_qid]};
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign rdata               = state_reg.rdata;
  assign tail_rung           = state_reg.rung;
  assign tail_pointer_value  = state_reg.tail;
  assign added_count         = state_reg.added;
  assign pending_count       = state_reg.pending;
  assign stray_write         = state_reg.stray;
  assign usable_units        = state_reg.usable;
  assign buffer_start_offset = state_reg.start;
  assign placement           = state_reg.place;

endmodule

// [src/bstd_pkg.sv]
// constants, field layout and carrier types for the buffer size
// capability and submission tail doorbell register block.
// assumes one controller clock and a plain strobe register port.
package bstd_pkg;

  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 32;
  localparam int NQ       = 4;
  localparam int PTR_W    = 16;
  localparam int DEPTH_W  = 17;
  localparam int STRIDE_W = 4;
  localparam int UNIT_W   = 20;
  localparam int GRAN_W   = 4;
  localparam int QID_W    = 2;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_BUF_SIZE = 16'h003c;
  localparam logic [ADDR_W-1:0] OFS_DB_BASE  = 16'h1000;

  // field positions of the size capability word
  localparam int CAPACITY_LSB = 12;
  localparam int GRAN_LSB = 8;
  localparam int RSV_W    = 3;
  localparam int WR_BIT   = 4;
  localparam int RD_BIT   = 3;
  localparam int LIST_BIT = 2;
  localparam int CQ_BIT   = 1;
  localparam int SQ_BIT   = 0;

  localparam logic [GRAN_W-1:0] GRAN_4K   = 4'h0;
  localparam logic [GRAN_W-1:0] GRAN_64K  = 4'h1;
  localparam logic [GRAN_W-1:0] GRAN_1M   = 4'h2;
  localparam logic [GRAN_W-1:0] GRAN_16M  = 4'h3;
  localparam logic [GRAN_W-1:0] GRAN_256M = 4'h4;
  localparam logic [GRAN_W-1:0] GRAN_4G   = 4'h5;
  localparam logic [GRAN_W-1:0] GRAN_64G  = 4'h6;

  // implementation constants of this controller's buffer
  localparam logic              BUF_PRESENT  = 1'b1;
  localparam logic [UNIT_W-1:0] BUF_CAPACITY = 20'h00100;
  localparam logic [GRAN_W-1:0] BUF_GRAN     = GRAN_4K;
  localparam logic [UNIT_W-1:0] BUF_START    = 20'h00040;
  localparam logic [UNIT_W-1:0] WINDOW_UNITS = 20'h00100;
  localparam logic              BUF_WR       = 1'b1;
  localparam logic              BUF_RD       = 1'b1;
  localparam logic              BUF_LISTS    = 1'b1;
  localparam logic              BUF_CQ       = 1'b1;
  localparam logic              BUF_SQ       = 1'b0;

  // doorbell spacing: a word is 4 bytes, tail and head alternate
  localparam int DB_WORD_SHIFT = 2;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [PTR_W-1:0]  ZERO_PTR  = 16'h0000;
  localparam logic [DEPTH_W-1:0] ZERO_CNT = 17'h00000;
  localparam logic [UNIT_W-1:0] ZERO_UNIT = 20'h00000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bstd_bus_req_t;

  // where the controller's own data paths may use the buffer
  typedef struct packed {
    logic wr_payload;
    logic rd_payload;
    logic lists;
    logic cq;
    logic sq;
  } bstd_place_t;

endpackage

// [src/bstd_tail_delta.sv]
// modulo distance between two tail pointers of one ring.
// assumes depth is the entry count, at least 1, and both tails below it.
`timescale 1ns/1ps
module bstd_tail_delta (
  input  wire logic [bstd_pkg::PTR_W-1:0]   old_tail,  // last tail seen
  input  wire logic [bstd_pkg::PTR_W-1:0]   new_tail,  // tail just written
  input  wire logic [bstd_pkg::DEPTH_W-1:0] depth,     // ring entries
  output logic      [bstd_pkg::DEPTH_W-1:0] added      // commands added
);
  import bstd_pkg::*;

  logic [DEPTH_W:0] wrapped;

  always_comb begin
    wrapped = {2'b00, new_tail} + {1'b0, depth} - {2'b00, old_tail};
    // wrap past the last entry adds the ring size back
    if (new_tail >= old_tail) begin
      added = DEPTH_W'({1'b0, new_tail} - {1'b0, old_tail});
    end else begin
      added = wrapped[DEPTH_W-1:0];
    end
  end

endmodule

// [bench/bstd_regs_assertions.sv]
// checker for the size capability word and the tail doorbells.
// sees only the ports of bstd_regs; one clock, async low reset.
`timescale 1ns/1ps
module bstd_regs_chk
  import bstd_pkg::*;
(
  input wire logic                                   clk,
  input wire logic                                   reset_n,
  input wire bstd_pkg::bstd_bus_req_t                bus_req,
  input wire logic [bstd_pkg::DATA_W-1:0]            rdata,
  input wire logic [bstd_pkg::STRIDE_W-1:0]          doorbell_stride,
  input wire logic [3:0][bstd_pkg::DEPTH_W-1:0]      queue_depth,
  input wire logic [3:0]                             queue_live,
  input wire logic [3:0]                             tail_rung,
  input wire logic [3:0][bstd_pkg::PTR_W-1:0]        tail_pointer_value,
  input wire logic [3:0][bstd_pkg::DEPTH_W-1:0]      added_count,
  input wire logic                                   stray_write,
  input wire logic [bstd_pkg::UNIT_W-1:0]            usable_units,
  input wire logic [bstd_pkg::UNIT_W-1:0]            buffer_start_offset,
  input wire bstd_pkg::bstd_place_t                  placement
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // lists force the queue bit, so the low field is not a plain copy
  localparam logic [DATA_W-1:0] SIZE_WORD = BUF_PRESENT ? {BUF_CAPACITY, BUF_GRAN, 3'h0,
    BUF_WR, BUF_RD, BUF_LISTS, BUF_CQ, BUF_SQ | BUF_LISTS} : ZERO_WORD;
  localparam logic [UNIT_W-1:0] CLIP = (BUF_CAPACITY < WINDOW_UNITS - BUF_START) ?
    BUF_CAPACITY : WINDOW_UNITS - BUF_START;
  logic [ADDR_W-1:0]  db_addr [4];
  logic [DEPTH_W-1:0] wrap_d  [4];

  a_rdata_idle: assert property (!bus_req.rd |=> rdata == ZERO_WORD)
    else $error("read data not zero outside its slot");
  a_size_word: assert property (
    bus_req.rd && bus_req.addr == OFS_BUF_SIZE |=> rdata == SIZE_WORD)
    else $error("size capability word wrong");
  a_fixed_fields: assert property (
    $past(reset_n) |-> usable_units == CLIP && buffer_start_offset == BUF_START
      && placement == SIZE_WORD[4:0])
    else $error("clipped size, location or placement wrong");
  a_lists_sq: assert property (placement.lists |-> placement.sq)
    else $error("lists without submission queue support");

  for (genvar g = 0; g < 4; g++) begin : g_q
    assign db_addr[g] = OFS_DB_BASE + ADDR_W'(2 * g) * (16'h0004 << doorbell_stride);
    assign wrap_d[g] = (bus_req.wdata[15:0] >= tail_pointer_value[g]) ?
      DEPTH_W'(bus_req.wdata[15:0] - tail_pointer_value[g]) :
      {1'b0, bus_req.wdata[15:0]} + queue_depth[g] - {1'b0, tail_pointer_value[g]};
    sequence s_tail_wr;
      bus_req.wr && bus_req.addr == db_addr[g];
    endsequence
    a_tail_store: assert property (
      s_tail_wr ##0 queue_live[g] |=> tail_rung[g]
        && tail_pointer_value[g] == $past(bus_req.wdata[15:0]))
      else $error("tail not stored or not rung");
    a_added_mod: assert property (
      s_tail_wr ##0 queue_live[g] |=> added_count[g] == $past(wrap_d[g]))
      else $error("added count not modulo depth");
    a_stray_ignored: assert property (
      s_tail_wr ##0 !queue_live[g] |=> stray_write && !tail_rung[g]
        && $stable(tail_pointer_value[g]))
      else $error("write to absent queue took effect");
    a_ring_cause: assert property (
      tail_rung[g] |-> $past(bus_req.wr && bus_req.addr == db_addr[g] && queue_live[g]))
      else $error("ring without a tail write");
    a_db_read: assert property (
      bus_req.rd && bus_req.addr == db_addr[g] |=>
        rdata == {16'h0000, $past(tail_pointer_value[g])})
      else $error("doorbell read upper half not zero");
  end
endmodule

bind bstd_regs bstd_regs_chk u_chk (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
  .rdata(rdata), .doorbell_stride(doorbell_stride), .queue_depth(queue_depth),
  .queue_live(queue_live), .tail_rung(tail_rung), .tail_pointer_value(tail_pointer_value),
  .added_count(added_count), .stray_write(stray_write), .usable_units(usable_units),
  .buffer_start_offset(buffer_start_offset), .placement(placement));

// [bench/bstd_host_model.sv]
// host software model: one strobe per call on the register port.
// assumes the bench calls wr and rd from one process only.
`timescale 1ns/1ps
module bstd_host_model
  import bstd_pkg::*;
(
  input  wire logic                        clk,     // bus clock
  input  wire logic [bstd_pkg::DATA_W-1:0] rdata,   // read data
  output bstd_pkg::bstd_bus_req_t          bus_req  // strobe request
);
  // queues, lists and payloads stay in host memory in this model
  initial bus_req = '{16'hffff, 32'hffff_ffff, 1'b0, 1'b0};
  // released lines show the inverse so a stale value never matches
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '{~a, ~d, 1'b0, 1'b0};
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{a, 32'h5a5a_a5a5, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '{~a, 32'ha5a5_5a5a, 1'b0, 1'b0};
    #1;
    d = rdata;
  endtask
endmodule

// [bench/tb.sv]
// self-checking bench for bstd_regs with the host model on its bus.
// assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb;
  import bstd_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [15:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } bstd_row_t;
  localparam bstd_row_t ROWS [7] = '{
    '{1'b0, 16'h003c, 32'h0, 32'h0010_001f},
    '{1'b1, 16'h003c, 32'hffff_ffff, 32'h0},
    '{1'b0, 16'h003c, 32'h0, 32'h0010_001f},
    '{1'b1, 16'h1000, 32'habcd_0005, 32'h0},
    '{1'b1, 16'h1004, 32'h0000_0009, 32'h0},
    '{1'b0, 16'h1000, 32'h0, 32'h0000_0005},
    '{1'b0, 16'h0100, 32'h0, 32'h0}};
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  bstd_bus_req_t         bus_req;
  logic [31:0]           rdata, got;
  logic [3:0]            doorbell_stride = 4'h0;
  logic [3:0][16:0]      queue_depth = {17'h10, 17'h8, 17'h10, 17'h10};
  logic [3:0]            queue_live = 4'hf;
  logic [3:0]            fetch_taken = 4'h0;
  logic [3:0]            tail_rung;
  logic [3:0][15:0]      tail_pointer_value;
  logic [3:0][16:0]      added_count, pending_count;
  logic                  stray_write;
  logic [19:0]           usable_units, buffer_start_offset;
  bstd_place_t           placement;
  int                    err_count = 0;
  int                    n_compared = 0;
  int                    cycles = 0;

  always #12.5 clk = ~clk;
  bstd_host_model host (.clk(clk), .rdata(rdata), .bus_req(bus_req));
  bstd_regs dut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
    .doorbell_stride(doorbell_stride), .queue_depth(queue_depth), .queue_live(queue_live),
    .fetch_taken(fetch_taken), .tail_rung(tail_rung), .tail_pointer_value(tail_pointer_value),
    .added_count(added_count), .pending_count(pending_count), .stray_write(stray_write),
    .usable_units(usable_units), .buffer_start_offset(buffer_start_offset),
    .placement(placement));

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("tails", 64'h0, tail_pointer_value)
    `CHK("usable", 20'h000c0, usable_units)
    `CHK("start", 20'h00040, buffer_start_offset)
    `CHK("placement", 5'h1f, placement)
    $display("reset test done");
  endtask

  // tail write and a fetch of queue 0 taken at the same edge
  task automatic ring_fetch(input logic [15:0] a, input logic [31:0] d);
    fork
      host.wr(a, d);
      begin
        @(posedge clk) fetch_taken <= 4'h1;
        @(posedge clk) fetch_taken <= 4'h0;
      end
    join
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    do_reset();
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) host.wr(ROWS[i].a, ROWS[i].d);
      else begin
        host.rd(ROWS[i].a, got);
        `CHK("row read", ROWS[i].e, got)
      end
    end
    $display("table test done");
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) doorbell_stride <= 4'(s);
      host.wr(16'h1000 + 16'(8 << s), 32'(s + 1));
      `CHK("stride tail", 16'(s + 1), tail_pointer_value[1])
      `CHK("ring", 4'h2, tail_rung)
    end
    $display("stride test done");
    @(posedge clk) doorbell_stride <= 4'h1;
    host.wr(16'h1020, 32'h6);
    host.wr(16'h1020, 32'h2);
    `CHK("wrap added", 17'h4, added_count[2])
    host.wr(16'h1030, 32'h3);
    host.wr(16'h1030, 32'h5);
    `CHK("pending", 17'h5, pending_count[3])
    @(posedge clk) fetch_taken <= 4'h8;
    @(posedge clk) fetch_taken <= 4'h0;
    #1;
    `CHK("fetched", 17'h4, pending_count[3])
    $display("wrap test done");
    @(posedge clk) queue_live <= 4'hd;
    host.wr(16'h1010, 32'h9);
    `CHK("stray", 1'b1, stray_write)
    `CHK("kept tail", 16'h4, tail_pointer_value[1])
    $display("stray test done");
    do_reset();
    ring_fetch(16'h1000, 32'h0);
    `CHK("floor", 17'h0, pending_count[0])
    ring_fetch(16'h1000, 32'h3);
    `CHK("ring and fetch", 17'h2, pending_count[0])
    $display("fetch test done");
    test_done();
  end
endmodule
